// ==== core/sptp_pkg.sv ====
// Constants, register map and carrier types of the switch port traffic policy block
//
// Contract
// RULE1 - One destination port may receive copies of source receive and transmit traffic.
// RULE2 - Mirroring may instead be split over separate receive and transmit destination ports.
// RULE3 - Any ports are mirror sources, receive and transmit chosen independently per port.
// RULE4 - Ingress limit applies to one class: all, bc+mc+flood, bc+mc, or bc.
// RULE5 - Egress limiting always counts all frames; classes apply to ingress only.
// RULE6 - Rate limits range 100 to 102400 kbps, or 256000 kbps on gigabit ports.
// RULE7 - Rate zero disables limiting; ingress and egress limits reset to zero.
// RULE8 - Every port has independent ingress and egress rate controls.
// RULE9 - Ingress rate is enforced by counting received packets of the selected class.
// RULE10 - VLAN mode is disabled, port-based or tag-based; resets to disabled. Tag-based mode is stored but forwards as disabled.
// RULE11 - Port-based mode forwards only to ports sharing a group with ingress port.
// RULE12 - Ports in no configured group together form one implicit extra group.
// RULE13 - Port-based mode ignores any VLAN tag when deciding forwarding.
// RULE14 - A common port in several groups is reachable by each; groups stay isolated.
// RULE15 - Membership storage holds up to 64 configured groups.
// RULE16 - A disabled port neither accepts nor sends frames, mirrored copies included.
// RULE17 - Limited-class frames beyond the configured rate are discarded; others pass.
// RULE18 - Mirrored copies bypass VLAN membership restriction.
package sptp_pkg;

  localparam int NPORTS     = 10;
  localparam int NGROUPS    = 64;
  localparam int GIGA_FIRST = 8;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [11:0] ADDR_MODE     = 12'h000;
  localparam logic [11:0] ADDR_PORT_EN  = 12'h004;
  localparam logic [11:0] ADDR_MIR_SRC  = 12'h008;
  localparam logic [11:0] ADDR_MIR_DST  = 12'h00c;
  localparam logic [11:0] ADDR_DROPCNT  = 12'h010;
  localparam logic [11:0] ADDR_RATE_BASE = 12'h100;
  localparam logic [11:0] ADDR_VGRP_BASE = 12'h400;
  localparam logic [11:0] ADDR_VGRP_END  = 12'h500;

  localparam logic [31:0] PORT_EN_RESET = 32'h000003ff;

  // Rate register fields
  localparam int RATE_W      = 18;
  localparam int RATE_EG_LSB = 0;
  localparam int RATE_IN_LSB = 18;
  localparam int CLASS_LSB   = 36;

  localparam logic [RATE_W-1:0] RATE_MIN      = 18'h00064;
  localparam logic [RATE_W-1:0] RATE_MAX_FAST = 18'h19000;
  localparam logic [RATE_W-1:0] RATE_MAX_GIGA = 18'h3e800;

  // Average frame size assumed by the packet counter, in bits
  localparam int FRAME_BITS   = 4096;
  localparam int WINDOW_US    = 1000;
  localparam int CLK_MHZ      = 25;
  localparam int WINDOW_CYC   = WINDOW_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SPTP_VLAN_OFF,
    SPTP_VLAN_PORT,
    SPTP_VLAN_TAG
  } sptp_vmode_t;

  typedef enum logic [1:0] {
    SPTP_CLS_ALL,
    SPTP_CLS_BMF,
    SPTP_CLS_BM,
    SPTP_CLS_B
  } sptp_class_t;

  // Frame descriptor presented by a port MAC or the fabric
  typedef struct packed {
    logic       bcast;
    logic       mcast;
    logic       flood;
    logic [3:0] port;
  } sptp_frame_t;

  typedef struct packed {
    logic [RATE_W-1:0] egress;
    logic [RATE_W-1:0] ingress;
  } sptp_rate_t;

endpackage

// ==== core/sptp_rate_meter.sv ====
// Per-port packet counter rate limiter
module sptp_rate_meter
  import sptp_pkg::*;
#(
  parameter int WINDOW = WINDOW_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [RATE_W-1:0] rateKbps,
  input  wire logic              tick,
  input  wire logic              countIt,
  output logic                   overLimit
);

  logic [RATE_W-1:0] cnt_reg;
  logic [RATE_W-1:0] cnt_next;
  logic [31:0]       allowed;

  // ************************************************************
  // Frames allowed per window from the configured rate
  // ************************************************************
  always_comb begin
    allowed   = (32'(rateKbps) * 32'(WINDOW_US)) / 32'(FRAME_BITS);
    if (allowed == 32'h0) begin
      allowed = 32'h1;
    end
    overLimit = (rateKbps != '0) && (32'(cnt_reg) >= allowed); // RULE7 RULE9
    cnt_next  = cnt_reg;
    if (tick) begin
      cnt_next = '0;
    end else if (countIt && !overLimit && cnt_reg != '1) begin
      cnt_next = cnt_reg + RATE_W'(1); // RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  a_meter_zero_open: assert property (@(posedge clk) disable iff (!nrst)
    (rateKbps == '0) |-> !overLimit) else $error("zero rate limited"); // RULE7
  a_meter_tick_clr: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> cnt_reg == '0) else $error("window did not clear"); // RULE9

endmodule

// ==== core/sptp_policy.sv ====
// Switch port traffic policy: mirroring, rate limiting, port-based VLAN
module sptp_policy
  import sptp_pkg::*;
#(
  parameter int WINDOW = WINDOW_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              rxValid,
  input  wire sptp_frame_t       rxFrame,
  input  wire logic [NPORTS-1:0] rxDestMask,
  output logic                   rxAccept,
  output logic [NPORTS-1:0]      fwdMask,
  input  wire logic              txValid,
  input  wire logic [3:0]        txPort,
  output logic                   txAccept,
  output logic [NPORTS-1:0]      mirMask
);

  // ************************************************************
  // Configuration state
  // ************************************************************
  sptp_vmode_t        vmode_reg, vmode_next;
  logic [NPORTS-1:0]  portEn_reg, portEn_next;
  logic [NPORTS-1:0]  mirRx_reg, mirRx_next;
  logic [NPORTS-1:0]  mirTx_reg, mirTx_next;
  logic [3:0]         dstRx_reg, dstRx_next;
  logic [3:0]         dstTx_reg, dstTx_next;
  logic               dstRxOn_reg, dstRxOn_next;
  logic               dstTxOn_reg, dstTxOn_next;
  sptp_rate_t         rate_reg [NPORTS];
  sptp_rate_t         rate_next [NPORTS];
  sptp_class_t        cls_reg [NPORTS];
  sptp_class_t        cls_next [NPORTS];
  logic [NPORTS-1:0]  grp_reg [NGROUPS];
  logic [NPORTS-1:0]  grpWrData;
  logic               grpWe;
  logic [5:0]         grpIdx;
  logic [31:0]        drop_reg, drop_next;
  logic               ack_reg, ack_next;
  logic [31:0]        rdat_reg, rdat_next;
  logic [31:0]        tick_reg, tick_next;
  logic               tick;

  logic               wbReq;
  logic [NPORTS-1:0]  inOver, egOver, inCount, egCount;
  logic [NPORTS-1:0]  reach, inGroup, ungrouped;
  logic               classHit;

  // Rate limits clamp to the port's legal span, zero stays zero
  function automatic logic [RATE_W-1:0] clampRate(input logic [RATE_W-1:0] r, input int p);
    logic [RATE_W-1:0] hi;
    hi = (p >= GIGA_FIRST) ? RATE_MAX_GIGA : RATE_MAX_FAST;
    if (r == '0) begin
      return '0;
    end else if (r < RATE_MIN) begin
      return RATE_MIN;
    end else if (r > hi) begin
      return hi;
    end
    return r;
  endfunction

  function automatic logic [NPORTS-1:0] onehot(input logic [3:0] p);
    return (p < 4'(NPORTS)) ? NPORTS'(1) << p : '0;
  endfunction

  function automatic logic inClass(input sptp_class_t c, input sptp_frame_t f);
    unique case (c)
      SPTP_CLS_ALL: return 1'b1;
      SPTP_CLS_BMF: return f.bcast | f.mcast | f.flood;
      SPTP_CLS_BM:  return f.bcast | f.mcast;
      SPTP_CLS_B:   return f.bcast;
    endcase
  endfunction

  assign wbReq = wb_cyc_i && wb_stb_i && !ack_reg;
  assign tick  = (tick_reg == 32'(WINDOW - 1));

  // ************************************************************
  // Wishbone register access
  // ************************************************************
  always_comb begin
    int p;
    p            = 0;
    vmode_next   = vmode_reg;
    portEn_next  = portEn_reg;
    mirRx_next   = mirRx_reg;
    mirTx_next   = mirTx_reg;
    dstRx_next   = dstRx_reg;
    dstTx_next   = dstTx_reg;
    dstRxOn_next = dstRxOn_reg;
    dstTxOn_next = dstTxOn_reg;
    rate_next    = rate_reg;
    cls_next     = cls_reg;
    grpWe        = 1'b0;
    grpIdx       = wb_adr_i[7:2];
    grpWrData    = wb_dat_i[NPORTS-1:0];
    ack_next     = wbReq;
    rdat_next    = rdat_reg;
    tick_next    = tick ? 32'h0 : tick_reg + 32'h1;
    drop_next    = drop_reg;
    if (wbReq) begin
      rdat_next = 32'h0;
      p = int'(wb_adr_i[5:2]);
      if (wb_adr_i >= ADDR_VGRP_BASE && wb_adr_i < ADDR_VGRP_END) begin
        rdat_next = 32'(grp_reg[grpIdx]); // RULE15
        grpWe     = wb_we_i && wb_sel_i[0];
      end else if (wb_adr_i[11:6] == ADDR_RATE_BASE[11:6] && p < NPORTS) begin
        rdat_next = {12'h0, 2'(cls_reg[p]), rate_reg[p].ingress[RATE_W-1:RATE_W-18]};
        if (wb_adr_i[6:2] < 5'd16 && wb_we_i) begin
          rate_next[p].ingress = clampRate(wb_dat_i[RATE_W-1:0], p); // RULE6 RULE8
          cls_next[p]          = sptp_class_t'(wb_dat_i[19:18]); // RULE4
        end
      end else if (wb_adr_i[11:6] == ADDR_RATE_BASE[11:6] + 6'h1 && p < NPORTS) begin
        rdat_next = 32'(rate_reg[p].egress);
        if (wb_we_i) begin
          rate_next[p].egress = clampRate(wb_dat_i[RATE_W-1:0], p); // RULE5 RULE6 RULE8
        end
      end else begin
        unique case (wb_adr_i)
          ADDR_MODE: begin
            rdat_next = 32'(vmode_reg);
            if (wb_we_i && wb_dat_i[1:0] != 2'h3) begin
              vmode_next = sptp_vmode_t'(wb_dat_i[1:0]); // RULE10
            end
          end
          ADDR_PORT_EN: begin
            rdat_next = 32'(portEn_reg);
            if (wb_we_i) portEn_next = wb_dat_i[NPORTS-1:0];
          end
          ADDR_MIR_SRC: begin
            rdat_next = {6'h0, mirTx_reg, 6'h0, mirRx_reg};
            if (wb_we_i) begin
              mirRx_next = wb_dat_i[NPORTS-1:0]; // RULE3
              mirTx_next = wb_dat_i[16+:NPORTS];
            end
          end
          ADDR_MIR_DST: begin
            rdat_next = {16'h0, dstTxOn_reg, 3'h0, dstTx_reg, dstRxOn_reg, 3'h0, dstRx_reg};
            if (wb_we_i) begin
              dstRx_next   = wb_dat_i[3:0]; // RULE1 RULE2
              dstRxOn_next = wb_dat_i[7];
              dstTx_next   = wb_dat_i[11:8];
              dstTxOn_next = wb_dat_i[15];
            end
          end
          ADDR_DROPCNT: begin
            rdat_next = drop_reg;
            if (wb_we_i) drop_next = 32'h0;
          end
          default: rdat_next = 32'h0;
        endcase
      end
    end
    // A refused rx frame and a refused tx frame in one cycle count as two drops
    if (rxValid && !rxAccept) drop_next = drop_next + 32'h1; // RULE17
    if (txValid && !txAccept) drop_next = drop_next + 32'h1; // RULE17
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vmode_reg   <= SPTP_VLAN_OFF; // RULE10
      portEn_reg  <= PORT_EN_RESET[NPORTS-1:0];
      mirRx_reg   <= '0;
      mirTx_reg   <= '0;
      dstRx_reg   <= '0;
      dstTx_reg   <= '0;
      dstRxOn_reg <= 1'b0;
      dstTxOn_reg <= 1'b0;
      for (int i = 0; i < NPORTS; i++) begin
        rate_reg[i] <= '0; // RULE7
        cls_reg[i]  <= SPTP_CLS_ALL;
      end
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
      tick_reg <= 32'h0;
      drop_reg <= 32'h0;
    end else begin
      vmode_reg   <= vmode_next;
      portEn_reg  <= portEn_next;
      mirRx_reg   <= mirRx_next;
      mirTx_reg   <= mirTx_next;
      dstRx_reg   <= dstRx_next;
      dstTx_reg   <= dstTx_next;
      dstRxOn_reg <= dstRxOn_next;
      dstTxOn_reg <= dstTxOn_next;
      rate_reg    <= rate_next;
      cls_reg     <= cls_next;
      ack_reg     <= ack_next;
      rdat_reg    <= rdat_next;
      tick_reg    <= tick_next;
      drop_reg    <= drop_next;
    end
  end

  // Membership memory, cleared by reset so every group starts empty
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int g = 0; g < NGROUPS; g++) grp_reg[g] <= '0;
    end else if (grpWe) begin
      grp_reg[grpIdx] <= grpWrData; // RULE15
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ************************************************************
  // Rate meters
  // ************************************************************
  assign classHit = rxFrame.port < 4'(NPORTS) && inClass(cls_reg[rxFrame.port], rxFrame);

  for (genvar i = 0; i < NPORTS; i++) begin : g_meter
    assign inCount[i] = rxValid && rxFrame.port == 4'(i) && inClass(cls_reg[i], rxFrame);
    assign egCount[i] = txValid && txPort == 4'(i); // RULE5
    sptp_rate_meter #(.WINDOW(WINDOW)) u_in (
      .clk       (clk),
      .nrst      (nrst),
      .rateKbps  (rate_reg[i].ingress),
      .tick      (tick),
      .countIt   (inCount[i]),
      .overLimit (inOver[i])
    );
    sptp_rate_meter #(.WINDOW(WINDOW)) u_eg (
      .clk       (clk),
      .nrst      (nrst),
      .rateKbps  (rate_reg[i].egress),
      .tick      (tick),
      .countIt   (egCount[i]),
      .overLimit (egOver[i])
    );
  end

  // ************************************************************
  // Forwarding decision
  // ************************************************************
  always_comb begin
    inGroup = '0;
    reach   = '0;
    for (int g = 0; g < NGROUPS; g++) begin
      inGroup = inGroup | grp_reg[g];
      if (grp_reg[g][rxFrame.port]) reach = reach | grp_reg[g]; // RULE11 RULE14
    end
    ungrouped = ~inGroup;
    if (ungrouped[rxFrame.port]) reach = reach | ungrouped; // RULE12
  end

  always_comb begin
    logic okIn;
    okIn     = rxFrame.port < 4'(NPORTS) && portEn_reg[rxFrame.port]; // RULE16
    rxAccept = rxValid && okIn && !(classHit && inOver[rxFrame.port]); // RULE17
    fwdMask  = '0;
    mirMask  = '0;
    if (rxAccept) begin
      // Tag contents are never looked at in port mode
      fwdMask = rxDestMask & portEn_reg; // RULE13 RULE16
      if (vmode_reg == SPTP_VLAN_PORT) fwdMask = fwdMask & reach; // RULE11
      if (mirRx_reg[rxFrame.port] && dstRxOn_reg) begin
        mirMask = mirMask | onehot(dstRx_reg); // RULE1 RULE3 RULE18
      end
    end
    txAccept = txValid && txPort < 4'(NPORTS) && portEn_reg[txPort] && !egOver[txPort]; // RULE16 RULE17
    if (txAccept && mirTx_reg[txPort] && dstTxOn_reg) begin
      mirMask = mirMask | onehot(dstTx_reg); // RULE2 RULE3
    end
    mirMask = mirMask & portEn_reg; // RULE16
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_vmode_reset: assert property (@(posedge clk) $rose(nrst) |-> vmode_reg == SPTP_VLAN_OFF)
    else $error("vlan mode not off after reset"); // RULE10
  a_port_isolate: assert property (@(posedge clk) disable iff (!nrst)
    (vmode_reg == SPTP_VLAN_PORT) |-> (fwdMask & ~reach) == '0) else $error("forward outside group"); // RULE11
  a_disabled_rx: assert property (@(posedge clk) disable iff (!nrst)
    (rxValid && !portEn_reg[rxFrame.port]) |-> !rxAccept) else $error("disabled port accepted"); // RULE16
  a_disabled_out: assert property (@(posedge clk) disable iff (!nrst)
    ((fwdMask | mirMask) & ~portEn_reg) == '0) else $error("disabled port sent"); // RULE16
  a_mirror_rx: assert property (@(posedge clk) disable iff (!nrst)
    (rxAccept && mirRx_reg[rxFrame.port] && dstRxOn_reg && portEn_reg[dstRx_reg])
      |-> mirMask[dstRx_reg]) else $error("rx copy missing"); // RULE1 RULE18
  a_mirror_tx: assert property (@(posedge clk) disable iff (!nrst)
    (txAccept && mirTx_reg[txPort] && dstTxOn_reg && portEn_reg[dstTx_reg])
      |-> mirMask[dstTx_reg]) else $error("tx copy missing"); // RULE2 RULE3
  a_rate_drop: assert property (@(posedge clk) disable iff (!nrst)
    (rxValid && classHit && inOver[rxFrame.port]) |-> !rxAccept) else $error("over rate passed"); // RULE17
  a_rate_class: assert property (@(posedge clk) disable iff (!nrst)
    (rxValid && portEn_reg[rxFrame.port] && !classHit && rxFrame.port < 4'(NPORTS)) |-> rxAccept)
    else $error("unlimited class dropped"); // RULE4
  a_eg_zero: assert property (@(posedge clk) disable iff (!nrst)
    (txValid && txPort < 4'(NPORTS) && portEn_reg[txPort] && rate_reg[txPort].egress == '0) |-> txAccept)
    else $error("zero egress limited"); // RULE7
  a_wb_ack_once: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  c_port_mode: cover property (@(posedge clk) disable iff (!nrst) vmode_reg == SPTP_VLAN_PORT && rxAccept);
  c_split_mir: cover property (@(posedge clk) disable iff (!nrst) mirMask[dstRx_reg] && mirMask[dstTx_reg]);
  c_rate_drop: cover property (@(posedge clk) disable iff (!nrst) rxValid && !rxAccept);
  c_eg_drop:   cover property (@(posedge clk) disable iff (!nrst) txValid && !txAccept);

endmodule

// ==== tb/sptp_mac_model.sv ====
// Port MAC and fabric model that offers frame descriptors to the policy block
module sptp_mac_model
  import sptp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rxAccept,
  input  wire logic [NPORTS-1:0] fwdMask,
  input  wire logic              txAccept,
  input  wire logic [NPORTS-1:0] mirMask,
  output logic                   rxValid,
  output sptp_frame_t            rxFrame,
  output logic [NPORTS-1:0]      rxDestMask,
  output logic                   txValid,
  output logic [3:0]             txPort
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rxValid    = 1'b0;
    rxFrame    = '0;
    rxDestMask = '0;
    txValid    = 1'b0;
    txPort     = 4'h0;
  end

  // One-cycle offer; idle descriptor lines show the inverse of the last value
  task automatic offer(input logic rv, input sptp_frame_t f, input logic [NPORTS-1:0] d, input logic tv,
                       input logic [3:0] tp, output logic [31:0] r);
    @(posedge clk);
    rxValid    <= rv;
    rxFrame    <= f;
    rxDestMask <= d;
    txValid    <= tv;
    txPort     <= tp;
    @(negedge clk);
    r = {10'h000, rxAccept, txAccept, mirMask, fwdMask};
    @(posedge clk);
    rxValid    <= 1'b0;
    txValid    <= 1'b0;
    rxFrame    <= ~f;
    rxDestMask <= ~d;
    txPort     <= ~tp;
  endtask
endmodule

// ==== tb/switch_port_traffic_policy_tb.sv ====
// Self-checking bench for the switch port traffic policy block
module switch_port_traffic_policy_tb
  import sptp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WIN = 200;

  typedef struct packed {
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } sptp_row_t;

  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [11:0]       wbAdr = 12'h000;
  logic [31:0]       wbDatW = 32'h0;
  logic [31:0]       wbDatR;
  logic [3:0]        wbSel = 4'h0;
  logic              wbWe = 1'b0;
  logic              wbCyc = 1'b0;
  logic              wbStb = 1'b0;
  logic              wbAck;
  logic              rxValid;
  sptp_frame_t       rxFrame;
  logic [NPORTS-1:0] rxDestMask;
  logic              rxAccept;
  logic [NPORTS-1:0] fwdMask;
  logic              txValid;
  logic [3:0]        txPort;
  logic              txAccept;
  logic [NPORTS-1:0] mirMask;
  logic [31:0]       q;
  logic [31:0]       res;
  int                n;
  int                n_errors = 0;
  int                checks = 0;

  sptp_row_t rows[13] = '{
    '{12'h000, 32'h1, 32'h1},
    '{12'h000, 32'h3, 32'h1},
    '{12'h000, 32'h2, 32'h2},
    '{12'h004, 32'h155, 32'h155},
    '{12'h008, 32'h20003, 32'h20003},
    '{12'h00c, 32'h8685, 32'h8685},
    '{12'h100, 32'hd9000, 32'hd9000},
    '{12'h120, 32'h3e800, 32'h3e800},
    '{12'h100, 32'h5, 32'h64},
    '{12'h14c, 32'h64, 32'h64},
    '{12'h400, 32'h103, 32'h103},
    '{12'h4fc, 32'h3ff, 32'h3ff},
    '{12'h020, 32'hffff, 32'h0}};
  logic [11:0] rstAdr[8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h100, 12'h14c, 12'h4fc};
  logic [3:0]  vPort[5] = '{4'h0, 4'h2, 4'h8, 4'h5, 4'h3};
  logic [9:0]  vExp[5] = '{10'h102, 10'h108, 10'h00f, 10'h2d0, 10'h104};
  logic [2:0]  inCls[4] = '{3'b000, 3'b001, 3'b010, 3'b100};
  logic [2:0]  outCls[4] = '{3'b000, 3'b000, 3'b001, 3'b010};

  sptp_policy #(.WINDOW(WIN)) i_sptp_policy (
    .clk(clk), .nrst(nrst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_we_i(wbWe),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rxValid(rxValid),
    .rxFrame(rxFrame), .rxDestMask(rxDestMask), .rxAccept(rxAccept), .fwdMask(fwdMask),
    .txValid(txValid), .txPort(txPort), .txAccept(txAccept), .mirMask(mirMask));

  sptp_mac_model i_sptp_mac_model (
    .clk(clk), .rxAccept(rxAccept), .fwdMask(fwdMask), .txAccept(txAccept), .mirMask(mirMask),
    .rxValid(rxValid), .rxFrame(rxFrame), .rxDestMask(rxDestMask), .txValid(txValid), .txPort(txPort));

  initial begin
    forever #20 clk = ~clk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mask(input logic [9:0] got, input logic [9:0] exp);
    chk_word({22'h0, got}, {22'h0, exp});
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
  endtask

  // Classic single cycle; waits for ack, bounded
  task automatic wb_xfer(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatW <= d;
    wbSel  <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      stop_test();
    end
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb_xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    wb_xfer(1'b0, a, 32'h0, r);
  endtask

  function automatic sptp_frame_t fr(input logic [2:0] k, input logic [3:0] p);
    return sptp_frame_t'({k, p});
  endfunction

  task automatic send(input logic rv, input sptp_frame_t f, input logic [9:0] d, input logic tv, input logic [3:0] tp);
    i_sptp_mac_model.offer(rv, f, d, tv, tp, res);
  endtask

  // Counts frames passed before the first refusal
  task automatic burst(input sptp_frame_t f, input logic isTx, output int cnt);
    cnt = 0;
    repeat (100) begin
      send(~isTx, f, 10'h001, isTx, f.port);
      if (res[isTx ? 20 : 21] !== 1'b1) break;
      cnt++;
    end
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wdat);
      rd(rows[i].adr, q);
      chk_word(q, rows[i].exp);
    end
    do_reset();
    foreach (rstAdr[i]) begin
      rd(rstAdr[i], q);
      chk_word(q, (rstAdr[i] == ADDR_PORT_EN) ? PORT_EN_RESET : 32'h0);
    end
    wr(12'h400, 32'h103);
    wr(12'h404, 32'h10c);
    wr(ADDR_MODE, 32'h1);
    foreach (vPort[i]) begin
      send(1'b1, fr(3'b000, vPort[i]), ~(10'h001 << vPort[i]), 1'b0, 4'h0);
      chk_mask(res[9:0], vExp[i]);
    end
    for (int m = 0; m < 3; m += 2) begin
      wr(ADDR_MODE, 32'(m));
      send(1'b1, fr(3'b000, 4'h0), 10'h3fe, 1'b0, 4'h0);
      chk_mask(res[9:0], 10'h3fe);
    end
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_MIR_SRC, 32'h20003);
    wr(ADDR_MIR_DST, 32'h8685);
    send(1'b1, fr(3'b000, 4'h0), 10'h002, 1'b1, 4'h1);
    chk_mask(res[19:10], 10'h060);
    send(1'b1, fr(3'b000, 4'h2), 10'h008, 1'b1, 4'h0);
    chk_mask(res[19:10], 10'h000);
    wr(ADDR_MIR_DST, 32'h8484);
    send(1'b1, fr(3'b000, 4'h0), 10'h002, 1'b1, 4'h1);
    chk_mask(res[19:10], 10'h010);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_PORT_EN, 32'h3ce);
    send(1'b1, fr(3'b000, 4'h0), 10'h002, 1'b1, 4'h0);
    chk_word(res, 32'h0);
    send(1'b1, fr(3'b000, 4'h1), 10'h3fd, 1'b1, 4'h1);
    chk_word(res, 32'h003003cc);
    rd(ADDR_DROPCNT, q);
    chk_word(q, 32'h2);
    wr(ADDR_PORT_EN, 32'h3ff);
    wr(ADDR_DROPCNT, 32'h0);
    for (int c = 0; c < 4; c++) begin
      // Let a window close so frames counted earlier do not shorten the burst
      repeat (WIN) @(posedge clk);
      wr(ADDR_RATE_BASE + 12'h004, {12'h000, c[1:0], 18'h00064});
      burst(fr(inCls[c], 4'h1), 1'b0, n);
      chk_flag(n >= 24 && n <= 48, 1'b1);
      if (c > 0) begin
        send(1'b1, fr(outCls[c], 4'h1), 10'h001, 1'b0, 4'h0);
        chk_flag(res[21], 1'b1);
      end
      send(1'b1, fr(3'b100, 4'h2), 10'h001, 1'b1, 4'h1);
      chk_flag(res[21] & res[20], 1'b1);
    end
    rd(ADDR_DROPCNT, q);
    chk_word(q, 32'h4);
    burst(fr(3'b100, 4'h2), 1'b0, n);
    chk_flag(n == 100, 1'b1);
    wr(12'h14c, 32'h64);
    burst(fr(3'b000, 4'h3), 1'b1, n);
    chk_flag(n >= 24 && n <= 48, 1'b1);
    stop_test();
  end
endmodule
